// ==== dv/analog_converter_control_bench.sv ====
`timescale 1ns/100ps
`default_nettype none
// ------------------------------
// converter control bench
// ------------------------------
module analog_converter_control_bench;
  logic ref_clk, resetn, avs_read, avs_write, avs_waitrequest, converter_power, sample_start, conv_clk_en;
  logic core_done, conversion_irq, global_irq_enable, irq_vector_taken;
  logic [7:0] avs_address, trigger_flags, rd_v;
  logic [31:0] avs_writedata, avs_readdata;
  logic [1:0] reference_select;
  logic [3:0] channel_select;
  logic [9:0] conversion_result;
  logic [5:0] pin_raw, pin_value, input_buffer_disable;
  logic [7:0] offs [7] = '{8'h78, 8'h79, 8'h7a, 8'h7b, 8'h7c, 8'h7e, 8'h7d}; // last one unmapped
  int miscompares, check_count, ref_v, chan_v, k, last_r;
  int exp_q [$]; // expected codes in start order
  bit la_v; // left alignment as written
  analog_converter_control dut_u (.ref_clk(ref_clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .reference_select(reference_select), .channel_select(channel_select),
    .converter_power(converter_power), .sample_start(sample_start), .conv_clk_en(conv_clk_en), .core_done(core_done),
    .conversion_result(conversion_result), .trigger_flags(trigger_flags), .global_irq_enable(global_irq_enable),
    .irq_vector_taken(irq_vector_taken), .conversion_irq(conversion_irq), .pin_raw(pin_raw), .pin_value(pin_value),
    .input_buffer_disable(input_buffer_disable));
  analog_core_model core_u (.ref_clk(ref_clk), .resetn(resetn), .converter_power(converter_power),
    .sample_start(sample_start), .reference_select(reference_select), .channel_select(channel_select),
    .conversion_result(conversion_result), .core_done(core_done));
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one bus cycle; request held until waitrequest is sampled low at a rising edge
  task automatic bus(input bit wr, input logic [7:0] a, input logic [7:0] wd);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h000000, wd};
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0 && n < 100)
    begin
      @(posedge ref_clk);
      n++;
    end
    rd_v = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge ref_clk);
    chk("bus", 16'h0000, 16'(n / 100));
  endtask : bus
  task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(nm, {8'h00, e}, {8'h00, rd_v});
  endtask : rdc
  // start with a stale flag cleared, and queue the code the core will return
  task automatic go(input logic [7:0] ctl);
    bus(1'b1, 8'h7a, ctl | 8'h10);
    exp_q.push_back((ref_v << 8) | (chan_v << 4) | (k & 15));
    k++;
  endtask : go
  task automatic wait_flag();
    int n;
    n = 0;
    rd_v = 8'h00;
    while (rd_v[4] !== 1'b1 && n < 2000)
    begin
      bus(1'b0, 8'h7a, 8'h00);
      n++;
    end
    chk("flag", 16'h0001, {15'h0000, rd_v[4]});
  endtask : wait_flag
  task automatic res_chk(input int r);
    logic [15:0] e;
    e = la_v ? {r[9:2], r[1:0], 6'h00} : {6'h00, r[9:0]};
    last_r = r;
    rdc("res low", 8'h78, e[7:0]);
    rdc("res high", 8'h79, e[15:8]);
  endtask : res_chk
  initial
  begin
    repeat (60000) @(posedge ref_clk);
    miscompares++;
    wrap_up();
  end
  initial
  begin
    {resetn, avs_read, avs_write, global_irq_enable, irq_vector_taken} = 5'h00;
    {avs_address, trigger_flags, avs_writedata, pin_raw} = '0;
    {k, ref_v, chan_v, la_v} = '0;
    void'($urandom(65));
    repeat (12) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    foreach (offs[i]) rdc("reset", offs[i], 8'h00);
    bus(1'b1, 8'h7c, 8'hff);
    rdc("sel mask", 8'h7c, 8'hef);
    for (int i = 0; i < 16; i++)
    begin
      bus(1'b1, 8'h7c, {i[1:0], 2'b00, i[3:0]});
      @(negedge ref_clk);
      chk("ref", 16'(i[1:0] == 2'b10 ? 2'b00 : i[1:0]), 16'(reference_select));
      chk("chan", 16'(i[3:0]), 16'(channel_select));
      @(posedge ref_clk);
    end
    bus(1'b1, 8'h7b, 8'h07);
    rdc("ctl b", 8'h7b, 8'h07);
    bus(1'b1, 8'h7e, 8'h15);
    pin_raw <= 6'($urandom);
    repeat (6) @(posedge ref_clk);
    chk("pins", 16'(pin_raw & 6'h2a), 16'(pin_value));
    {ref_v, chan_v} = {32'd1, 32'd5};
    bus(1'b1, 8'h7c, 8'h45);
    go(8'hc0);
    rdc("busy", 8'h7a, 8'hc0);
    wait_flag();
    rdc("idle", 8'h7a, 8'h90);
    res_chk(exp_q.pop_front());
    go(8'hc1);
    bus(1'b1, 8'h7c, 8'h67);
    chk("chan held", 16'h0005, 16'(channel_select));
    la_v = 1'b1;
    res_chk(last_r);
    wait_flag();
    res_chk(exp_q.pop_front());
    chk("chan moved", 16'h0007, 16'(channel_select));
    chan_v = 7;
    bus(1'b0, 8'h78, 8'h00);
    go(8'hc0);
    wait_flag();
    void'(exp_q.pop_front());
    res_chk(last_r);
    go(8'hc0);
    wait_flag();
    res_chk(exp_q.pop_front());
    global_irq_enable <= 1'b1;
    go(8'hc8);
    wait_flag();
    chk("irq", 16'h0001, 16'(conversion_irq));
    global_irq_enable <= 1'b0;
    @(posedge ref_clk);
    chk("irq off", 16'h0000, 16'(conversion_irq));
    global_irq_enable <= 1'b1;
    irq_vector_taken <= 1'b1;
    @(posedge ref_clk);
    irq_vector_taken <= 1'b0;
    @(posedge ref_clk);
    chk("vector", 16'h0000, 16'(conversion_irq));
    rdc("cleared", 8'h7a, 8'h88);
    res_chk(exp_q.pop_front());
    go(8'hc0);
    bus(1'b1, 8'h7a, 8'h00);
    chk("power", 16'h0000, 16'(converter_power));
    repeat (80) @(posedge ref_clk);
    rdc("aborted", 8'h7a, 8'h00);
    void'(exp_q.pop_front());
    go(8'hc7);
    wait_flag();
    res_chk(exp_q.pop_front());
    bus(1'b1, 8'h7a, 8'hb0);
    for (int s = 1; s < 8; s++)
    begin
      bus(1'b1, 8'h7b, 8'(s));
      trigger_flags <= 8'h01 << (s % 7 + 1);
      repeat (60) @(posedge ref_clk);
      rdc("other src", 8'h7a, 8'ha0);
      trigger_flags <= 8'h01 << s;
      repeat (60) @(posedge ref_clk);
      rdc("own src", 8'h7a, 8'hb0);
      trigger_flags <= 8'h00;
      bus(1'b1, 8'h7a, 8'hb0);
    end
    bus(1'b1, 8'h7a, 8'h90);
    trigger_flags <= 8'h80;
    repeat (60) @(posedge ref_clk);
    rdc("auto off", 8'h7a, 8'h80);
    trigger_flags <= 8'h04;
    bus(1'b1, 8'h7a, 8'hb0);
    bus(1'b1, 8'h7b, 8'h02);
    repeat (60) @(posedge ref_clk);
    rdc("switch", 8'h7a, 8'hb0);
    bus(1'b1, 8'h7b, 8'h00);
    repeat (60) @(posedge ref_clk);
    rdc("to free", 8'h7a, 8'hb0);
    go(8'he0);
    wait_flag();
    bus(1'b1, 8'h7a, 8'hb0);
    rdc("start kept", 8'h7a, 8'he0);
    wait_flag();
    bus(1'b1, 8'h7a, 8'h00);
    wrap_up();
  end
endmodule : analog_converter_control_bench
`default_nettype wire

// ==== dv/analog_core_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ---------------------------
// behavioural analog core
// ---------------------------
module analog_core_model #(
  parameter int RES_W = 10
)(
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // control from the converter logic
  input wire logic converter_power,
  input wire logic sample_start,
  input wire logic [1:0] reference_select,
  input wire logic [3:0] channel_select,
  // answer to the converter logic
  output logic [RES_W-1:0] conversion_result,
  output logic core_done
);
  logic [RES_W-1:0] res_ff; // last sampled code
  logic [3:0] seq_ff; // starts seen, low bits
  // code names reference, channel and sequence so the bench can predict it
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      res_ff <= {RES_W{1'b0}};
      seq_ff <= 4'h0;
    end
    else if (sample_start)
    begin
      res_ff <= RES_W'({reference_select, channel_select, seq_ff});
      seq_ff <= seq_ff + 4'h1;
    end
  end
  // an unpowered core holds nothing; the inverse keeps stale data from passing
  assign conversion_result = converter_power ? res_ff : ~res_ff;
  assign core_done = 1'b0; // the control logic times conversions itself
endmodule : analog_core_model
`default_nettype wire

// ==== dv/conv_ctrl_sva.sv ====
`timescale 1ns/100ps
`default_nettype none
// ----------------------------
// converter control checker
// ----------------------------
module conv_ctrl_sva (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // bus handshake
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // analog core side
  input wire logic [1:0] reference_select,
  input wire logic [3:0] channel_select,
  input wire logic converter_power,
  input wire logic sample_start,
  input wire logic conv_clk_en,
  // interrupt and pins
  input wire logic global_irq_enable,
  input wire logic irq_vector_taken,
  input wire logic conversion_irq,
  input wire logic [5:0] pin_raw,
  input wire logic [5:0] pin_value,
  input wire logic [5:0] input_buffer_disable
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  logic [5:0] edges_ff; // converter clock pulses since last start, saturating
  logic armed_ff; // a start was seen since power came on
  logic fresh_ff; // next start is the first after power-up
  logic first_ff; // running conversion is the long one
  // pulse counter; saturation keeps long idle gaps from wrapping
  always_ff @(posedge ref_clk)
  begin
    if (!resetn || sample_start)
      edges_ff <= 6'h00;
    else if (conv_clk_en && edges_ff != 6'h3f)
      edges_ff <= edges_ff + 6'h01;
  end
  // power-off forgets the conversion in flight
  always_ff @(posedge ref_clk)
  begin
    if (!resetn || (!converter_power && !sample_start))
    begin
      armed_ff <= 1'b0;
      fresh_ff <= 1'b1;
      first_ff <= 1'b0;
    end
    else if (sample_start)
    begin
      armed_ff <= 1'b1;
      fresh_ff <= 1'b0;
      first_ff <= fresh_ff;
    end
  end
  sequence s_req_open;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_req_done;
    s_req_open ##1 !avs_waitrequest;
  endsequence
  sequence s_sel_moved;
    $changed(channel_select) || $changed(reference_select);
  endsequence
  chk_one_wait: assert property ($rose(avs_read || avs_write) |-> s_req_done)
    else $error("bus answer not one cycle late");
  chk_ref_legal: assert property (reference_select != 2'b10)
    else $error("reserved reference driven");
  chk_sel_held: assert property (s_sel_moved |-> !armed_ff || $past(sample_start) || edges_ff >= (first_ff ? 6'd25 : 6'd13))
    else $error("selection moved in conversion");
  chk_off_idle: assert property (sample_start |=> converter_power)
    else $error("start while off");
  chk_conv_length: assert property (sample_start && armed_ff |-> edges_ff >= (first_ff ? 6'd25 : 6'd13))
    else $error("conversion too short");
  chk_clk_spacing: assert property (conv_clk_en |=> !conv_clk_en)
    else $error("converter clock too fast");
  chk_irq_global: assert property (conversion_irq |-> global_irq_enable)
    else $error("irq without global enable");
  chk_vector_clear: assert property (irq_vector_taken && conversion_irq && !$past(conv_clk_en) |=> !conversion_irq)
    else $error("vector did not clear flag");
  chk_pin_mask: assert property ((pin_value & input_buffer_disable) == 6'h00)
    else $error("disabled pin reads one");
  chk_pin_follow: assert property (($stable(pin_raw) && $stable(input_buffer_disable)) [*5]
    |-> pin_value == (pin_raw & ~input_buffer_disable))
    else $error("pin value stale");
endmodule : conv_ctrl_sva
bind analog_converter_control conv_ctrl_sva chk_u (.ref_clk(ref_clk), .resetn(resetn), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .reference_select(reference_select),
  .channel_select(channel_select), .converter_power(converter_power), .sample_start(sample_start),
  .conv_clk_en(conv_clk_en), .global_irq_enable(global_irq_enable), .irq_vector_taken(irq_vector_taken),
  .conversion_irq(conversion_irq), .pin_raw(pin_raw), .pin_value(pin_value),
  .input_buffer_disable(input_buffer_disable));
`default_nettype wire

// ==== rtl/analog_converter_control.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "conv_ctrl_defines.svh"
// Summary of operation
// - reference code 00 pin, 01 supply, 11 bandgap
// - reference/channel changes apply after conversion completes
// - left-align bit changes readout immediately
// - selection register bit 4 reads zero
// - channel codes 0-7 inputs, 14 bandgap, 15 ground
// - enable powers; clearing aborts conversion
// - first conversion 25 clocks, later 13
// - start bit starts one; free running continues
// - start reads busy; writing zero ignored
// - auto trigger starts on source rising edge
// - done flag set on finish; vector/one clears
// - interrupt when flag, enable, global all set
// - prescaler divides by 2 up to 128
// - result byte layout follows alignment bit
// - low-byte read locks result until high read
// - trigger source code table: code 0 free running, codes 1-7 sources
// - rising flag edge; ignored when auto off
// - source switch may trigger; free running never
// - disable bit blanks matching digital input
// - free running restarts on each completion
module analog_converter_control
  import conv_ctrl_pkg::*;
#(
  parameter int RES_W = 10
)(
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // avalon-mm slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // analog core
  output logic [1:0] reference_select,
  output logic [3:0] channel_select,
  output logic converter_power,
  output logic sample_start,
  output logic conv_clk_en,
  input wire logic core_done,
  input wire logic [RES_W-1:0] conversion_result,
  // trigger flags, sources 1..7 at bits 1..7, bit 0 unused
  input wire logic [7:0] trigger_flags,
  // cpu interrupt
  input wire logic global_irq_enable,
  input wire logic irq_vector_taken,
  output logic conversion_irq,
  // digital input buffers of analog pins 0..5
  input wire logic [5:0] pin_raw,
  output logic [5:0] pin_value,
  output logic [5:0] input_buffer_disable
);
  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic [7:0] in_ref_sel_ff; // software view of selection register
  logic [1:0] ref_active_ff; // reference used by the core
  logic [3:0] chan_active_ff; // channel used by the core
  logic converter_enable_ff;
  logic auto_trigger_enable_ff;
  logic conversion_done_flag_ff;
  logic completion_irq_enable_ff;
  logic [2:0] clock_divider_select_ff;
  logic [7:0] ctrl_b_ff;
  logic [5:0] did_ff;
  logic [RES_W-1:0] result_ff;
  logic lock_ff; // low byte read, waiting for high
  logic first_pending_ff; // next conversion is the long one
  conv_state_e state_ff;
  logic [4:0] cycles_ff; // converter clocks left
  logic [6:0] presc_ff;
  logic [7:0] trig_sel_d_ff; // selected flag, previous cycle
  logic [7:0] pin_s1_ff;
  logic [5:0] pin_s2_ff;
  logic ack_ff; // one wait state per access
  logic [31:0] rdata_ff;
  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic wr_go, rd_go, wr_a, wr_b, wr_mux, wr_did;
  logic [7:0] wd;
  logic busy, finish, start_req, trig_edge, sel_flag;
  logic [7:0] res_hi, res_lo;
  assign wd = avs_writedata[7:0];
  // writes land at the edge where waitrequest is low, never earlier
  assign wr_go = avs_write & ack_ff;
  assign rd_go = avs_read & ~ack_ff;
  // waitrequest drops for one cycle after the access is seen
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
  assign wr_a = wr_go & (avs_address == `OFS_CTRL_A);
  assign wr_b = wr_go & (avs_address == `OFS_CTRL_B);
  assign wr_mux = wr_go & (avs_address == `OFS_IN_REF_SEL);
  assign wr_did = wr_go & (avs_address == `OFS_DIG_DISABLE);
  assign busy = (state_ff != st_idle);
  assign avs_readdata = rdata_ff;

  // access handshake flop
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      ack_ff <= 1'b0;
    else
      ack_ff <= (avs_read | avs_write) & ~ack_ff;
  end

  // ---------------------------------------------------------------
  // result byte layout
  // ---------------------------------------------------------------
  always_comb
  begin
    if (in_ref_sel_ff[`MUX_LEFT_ALIGN])
    begin
      res_hi = result_ff[9:2];
      res_lo = {result_ff[1:0], 6'h00};
    end
    else
    begin
      res_hi = {6'h00, result_ff[9:8]};
      res_lo = result_ff[7:0];
    end
  end

  // read data, registered; unmapped reads return zero
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      rdata_ff <= 32'h0000_0000;
    else if (rd_go)
    begin
      case (avs_address)
        `OFS_RESULT_LOW: rdata_ff <= {24'h0, res_lo};
        `OFS_RESULT_HIGH: rdata_ff <= {24'h0, res_hi};
        `OFS_CTRL_A: rdata_ff <= {24'h0, converter_enable_ff, busy, auto_trigger_enable_ff,
          conversion_done_flag_ff, completion_irq_enable_ff, clock_divider_select_ff};
        `OFS_CTRL_B: rdata_ff <= {24'h0, ctrl_b_ff};
        `OFS_IN_REF_SEL: rdata_ff <= {24'h0, in_ref_sel_ff & `MUX_MASK};
        `OFS_DIG_DISABLE: rdata_ff <= {26'h0, did_ff};
        default: rdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------
  // selection register; bit 4 never stored
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      in_ref_sel_ff <= `RESET_BYTE;
    else if (wr_mux)
      in_ref_sel_ff <= wd & `MUX_MASK;
  end

  // core sees selection only between conversions
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      ref_active_ff <= 2'b00;
      chan_active_ff <= 4'h0;
    end
    else if (!busy || finish)
    begin
      ref_active_ff <= in_ref_sel_ff[7:6];
      chan_active_ff <= in_ref_sel_ff[3:0];
    end
  end
  // reserved reference code falls back to the pin, a safe choice
  assign reference_select = (ref_active_ff == `REF_RESERVED) ? 2'b00 : ref_active_ff;
  assign channel_select = chan_active_ff;

  // control a fields
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      converter_enable_ff <= 1'b0;
      auto_trigger_enable_ff <= 1'b0;
      completion_irq_enable_ff <= 1'b0;
      clock_divider_select_ff <= 3'b000;
    end
    else if (wr_a)
    begin
      converter_enable_ff <= wd[`CTLA_ENABLE];
      auto_trigger_enable_ff <= wd[`CTLA_AUTO];
      completion_irq_enable_ff <= wd[`CTLA_IRQ_EN];
      clock_divider_select_ff <= wd[2:0];
    end
  end

  // control b keeps only the source and comparator bits
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      ctrl_b_ff <= `RESET_BYTE;
    else if (wr_b)
      ctrl_b_ff <= wd & `CTLB_MASK;
  end

  // digital input disables
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      did_ff <= 6'h00;
    else if (wr_did)
      did_ff <= wd[5:0] & 6'(`DID_MASK);
  end
  assign input_buffer_disable = did_ff;

  // pins are asynchronous, two flops then masking
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      pin_s1_ff <= 8'h00;
      pin_s2_ff <= 6'h00;
      pin_value <= 6'h00;
    end
    else
    begin
      pin_s1_ff <= {2'b00, pin_raw};
      pin_s2_ff <= pin_s1_ff[5:0];
      // new mask applies at the write edge, so a set bit never lets a one through
      pin_value <= pin_s2_ff & ~(wr_did ? wd[5:0] : did_ff);
    end
  end

  // ---------------------------------------------------------------
  // prescaler
  // ---------------------------------------------------------------
  logic [6:0] div_mask;
  always_comb
  begin
    case (clock_divider_select_ff)
      3'd0, 3'd1: div_mask = 7'h01;
      3'd2: div_mask = 7'h03;
      3'd3: div_mask = 7'h07;
      3'd4: div_mask = 7'h0f;
      3'd5: div_mask = 7'h1f;
      3'd6: div_mask = 7'h3f;
      default: div_mask = 7'h7f;
    endcase
  end
  // free counter held while off, so power-up starts aligned
  always_ff @(posedge ref_clk)
  begin
    if (!resetn || !converter_enable_ff)
      presc_ff <= 7'h00;
    else
      presc_ff <= presc_ff + 7'h01;
  end
  assign conv_clk_en = converter_enable_ff && ((presc_ff & div_mask) == div_mask);

  // ---------------------------------------------------------------
  // trigger sources
  // ---------------------------------------------------------------
  // selected flag; code 0 free running never yields an edge
  assign sel_flag = (ctrl_b_ff[2:0] != 3'd0) && trigger_flags[ctrl_b_ff[2:0]];
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      trig_sel_d_ff <= 8'h00;
    else
      trig_sel_d_ff <= {7'h00, sel_flag};
  end
  // compare of selected flag covers source switching too
  assign trig_edge = auto_trigger_enable_ff && sel_flag && !trig_sel_d_ff[0];

  // start request from software or trigger; free running restarts in the sequencer at finish
  // a write that clears the enable cancels any start seen with it
  logic keep_on;
  assign keep_on = !(wr_a && !wd[`CTLA_ENABLE]);
  assign start_req = converter_enable_ff && !busy && keep_on &&
    ((wr_a && wd[`CTLA_START]) || trig_edge);
  // a start written with enable in the same write
  logic start_with_en;
  assign start_with_en = wr_a && wd[`CTLA_ENABLE] && wd[`CTLA_START] && !busy;

  // ---------------------------------------------------------------
  // conversion sequencer
  // ---------------------------------------------------------------
  logic free_run;
  assign free_run = auto_trigger_enable_ff && (ctrl_b_ff[2:0] == 3'd0);
  // a conversion cut off by disable never completes
  assign finish = (state_ff == st_finish) && converter_enable_ff;
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
    begin
      state_ff <= st_idle;
      cycles_ff <= 5'd0;
      first_pending_ff <= 1'b1;
    end
    else if (!converter_enable_ff && !start_with_en)
    begin
      state_ff <= st_idle;
      first_pending_ff <= 1'b1;
    end
    else
    begin
      case (state_ff)
        st_idle:
          if (start_req || start_with_en)
          begin
            state_ff <= st_convert;
            cycles_ff <= first_pending_ff ? `FIRST_CONV_CYCLES : `NORMAL_CONV_CYCLES;
            first_pending_ff <= 1'b0;
          end
        st_convert:
          if (conv_clk_en)
          begin
            if (cycles_ff == 5'd1)
              state_ff <= st_finish;
            else
              cycles_ff <= cycles_ff - 5'd1;
          end
        st_finish:
          if (free_run)
          begin
            state_ff <= st_convert;
            cycles_ff <= `NORMAL_CONV_CYCLES;
          end
          else
            state_ff <= st_idle;
        default: state_ff <= st_idle;
      endcase
    end
  end
  assign converter_power = converter_enable_ff;
  // free running restarts sample too, with the selection still in force
  assign sample_start = ((state_ff == st_idle) && (start_req || start_with_en)) ||
    (finish && free_run && keep_on);

  // ---------------------------------------------------------------
  // result, lock and flag
  // ---------------------------------------------------------------
  logic rd_lo, rd_hi;
  assign rd_lo = rd_go && (avs_address == `OFS_RESULT_LOW);
  assign rd_hi = rd_go && (avs_address == `OFS_RESULT_HIGH);
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      lock_ff <= 1'b0;
    else if (rd_lo)
      lock_ff <= 1'b1;
    else if (rd_hi)
      lock_ff <= 1'b0;
  end
  // core_done is ignored: the sequencer count marks completion
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      result_ff <= 10'h000;
    else if (finish && !lock_ff)
      result_ff <= conversion_result;
  end
  // set beats clear when both land in one cycle
  always_ff @(posedge ref_clk)
  begin
    if (!resetn)
      conversion_done_flag_ff <= 1'b0;
    else if (finish)
      conversion_done_flag_ff <= 1'b1;
    else if (irq_vector_taken || (wr_a && wd[`CTLA_DONE]))
      conversion_done_flag_ff <= 1'b0;
  end
  assign conversion_irq = conversion_done_flag_ff && completion_irq_enable_ff && global_irq_enable;
  logic unused_ok;
  assign unused_ok = core_done & trig_sel_d_ff[7];
endmodule : analog_converter_control
`default_nettype wire

// ==== rtl/conv_ctrl_defines.svh ====
`ifndef CONV_CTRL_DEFINES_SVH
`define CONV_CTRL_DEFINES_SVH
// ---------------------------------------------------------------
// register byte addresses
// ---------------------------------------------------------------
`define OFS_RESULT_LOW 8'h78
`define OFS_RESULT_HIGH 8'h79
`define OFS_CTRL_A 8'h7a
`define OFS_CTRL_B 8'h7b
`define OFS_IN_REF_SEL 8'h7c
`define OFS_DIG_DISABLE 8'h7e
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define CTLA_ENABLE 7
`define CTLA_START 6
`define CTLA_AUTO 5
`define CTLA_DONE 4
`define CTLA_IRQ_EN 3
`define MUX_LEFT_ALIGN 5
// ---------------------------------------------------------------
// reset values, timing counts, reserved reference code and masks
// ---------------------------------------------------------------
`define RESET_BYTE 8'h00
`define FIRST_CONV_CYCLES 5'd25
`define NORMAL_CONV_CYCLES 5'd13
`define REF_RESERVED 2'b10
`define MUX_MASK 8'hef
`define CTLB_MASK 8'h47
`define DID_MASK 8'h3f
`endif

// ==== rtl/conv_ctrl_pkg.sv ====
package conv_ctrl_pkg;
  // conversion sequencer states
  typedef enum logic [1:0] {st_idle, st_convert, st_finish} conv_state_e;
  // selected reference
  typedef enum logic [1:0] {ref_pin, ref_supply, ref_reserved, ref_bandgap} ref_sel_e;
endpackage : conv_ctrl_pkg
